//--- hdl/sdu_params.svh
`ifndef SDU_PARAMS_SVH
`define SDU_PARAMS_SVH

// Opcode field values, bits 24:19
`define SDU_OP_STD          6'h07
`define SDU_OP_STDA         6'h17
`define SDU_OP_STORE_DOUBLE_COPRO         6'h37
`define SDU_OP_STORE_COPRO_QUEUE_ENTRY        6'h36
`define SDU_OP_STORE_DOUBLE_FLOAT         6'h27
`define SDU_OP_STORE_FLOAT_QUEUE_ENTRY        6'h26
`define SDU_PRIMARY_STORE   2'h3

// APB register byte offsets
`define SDU_ADDR_CTRL       12'h000
`define SDU_ADDR_STATUS     12'h004
`define SDU_ADDR_INT_STAT   12'h008
`define SDU_ADDR_INT_MASK   12'h00C
`define SDU_ADDR_FQ_DEPTH   12'h010
`define SDU_ADDR_LAST_TRAP  12'h014

// Control register fields
`define SDU_CTRL_COPRO_EN   0
`define SDU_CTRL_FLOAT_EN   1
`define SDU_CTRL_SUPER      2
`define SDU_CTRL_COPRO_PRES 3
`define SDU_CTRL_FLOAT_PRES 4
`define SDU_CTRL_FLOAT_EXC  5
`define SDU_CTRL_RESET      32'h0000_0000

// Interrupt status bits
`define SDU_INT_DONE        0
`define SDU_INT_TRAP        1
`define SDU_INT_WIDTH       2

`define SDU_WORD_STEP       32'h0000_0004
`define SDU_DW_ALIGN_MASK   32'h0000_0007

`endif

//--- hdl/sdu_pkg.sv
package sdu_pkg;

    typedef enum logic [3:0] {
        SDU_TRAP_NONE       = 4'h0,
        SDU_TRAP_ILLEGAL    = 4'h1,
        SDU_TRAP_PRIV       = 4'h2,
        SDU_TRAP_MISALIGN   = 4'h3,
        SDU_TRAP_DATA_FAULT = 4'h4,
        SDU_TRAP_COPRO_OFF  = 4'h5,
        SDU_TRAP_FLOAT_OFF  = 4'h6,
        SDU_TRAP_FLOAT_ERR  = 4'h7
    } sdu_trap_e;

    typedef enum logic [2:0] {
        SDU_KIND_INT  = 3'h0,
        SDU_KIND_ALT  = 3'h1,
        SDU_KIND_CP   = 3'h2,
        SDU_KIND_CPQ  = 3'h3,
        SDU_KIND_FP   = 3'h4,
        SDU_KIND_FPQ  = 3'h5,
        SDU_KIND_NONE = 3'h7
    } sdu_kind_e;

    typedef enum logic [2:0] {
        SDU_ST_IDLE  = 3'h0,
        SDU_ST_FETCH = 3'h1,
        SDU_ST_HIGH  = 3'h2,
        SDU_ST_LOW   = 3'h3,
        SDU_ST_TRAP  = 3'h4
    } sdu_state_e;

    // Instruction issue from the pipeline
    typedef struct packed {
        logic [31:0] instr;
        logic [31:0] src1_val;
        logic [31:0] src2_val;
    } sdu_issue_s;

    // Data returned for the register pair or queue front
    typedef struct packed {
        logic [31:0] hi_word;
        logic [31:0] lo_word;
    } sdu_pair_s;

    // One memory write request
    typedef struct packed {
        logic        valid;
        logic [31:0] addr;
        logic [7:0]  space;
        logic        alt;
        logic [31:0] data;
    } sdu_mem_s;

endpackage

//--- hdl/sdu_store_double.sv
// Notes on behaviour
// - integer pair store writes even then odd
// - address is src1 plus src2 or immediate
// - even word at address, odd at plus four
// - data fault leaves both words untouched
// - alternate store uses space field, register sum
// - alternate store: immediate illegal, needs supervisor
// - coprocessor pair store, even first
// - coprocessor disabled or absent traps
// - coprocessor queue store privileged, address then instruction
// - float pair store, even first
// - float disabled or absent traps, memory unchanged
// - float queue store privileged, address then instruction
// - float queue advances in exception mode
// - float stores take pending float exception
`timescale 1ns/100ps
`default_nettype none
`include "sdu_params.svh"

module sdu_store_double
    import sdu_pkg::*;
#(
    parameter int FQ_DEPTH_W = 4
) (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        clk_en,
    input  wire logic        issue_valid,
    input  wire sdu_issue_s  issue,
    output var  logic        issue_ready,
    output var  logic [4:0]  pair_index,
    output var  sdu_kind_e   pair_kind,
    output var  logic        pair_req,
    input  wire logic        pair_valid,
    input  wire sdu_pair_s   pair,
    input  wire logic        float_exc_pending,
    output var  sdu_mem_s    mem_wr,
    input  wire logic        mem_ready,
    input  wire logic        mem_fault,
    output var  logic        fq_advance,
    output var  logic        trap_valid,
    output var  sdu_trap_e   trap_code,
    output var  logic        done,
    output var  logic        irq,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr
);

    function automatic sdu_kind_e sdu_kind_of(input logic [31:0] ins);
        if (ins[31:30] != `SDU_PRIMARY_STORE) begin
            return SDU_KIND_NONE;
        end
        case (ins[24:19])
            `SDU_OP_STD:   return SDU_KIND_INT;
            `SDU_OP_STDA:  return SDU_KIND_ALT;
            `SDU_OP_STORE_DOUBLE_COPRO:  return SDU_KIND_CP;
            `SDU_OP_STORE_COPRO_QUEUE_ENTRY: return SDU_KIND_CPQ;
            `SDU_OP_STORE_DOUBLE_FLOAT:  return SDU_KIND_FP;
            `SDU_OP_STORE_FLOAT_QUEUE_ENTRY: return SDU_KIND_FPQ;
            default:       return SDU_KIND_NONE;
        endcase
    endfunction

    sdu_state_e             state_reg;
    sdu_kind_e              kind_reg;
    logic [31:0]            addr_reg;
    logic [7:0]             space_reg;
    logic [31:0]            lo_reg;
    logic [31:0]            ctrl_reg;
    logic [`SDU_INT_WIDTH-1:0] int_stat_reg;
    logic [`SDU_INT_WIDTH-1:0] int_mask_reg;
    logic [FQ_DEPTH_W-1:0]  fq_depth_reg;
    sdu_trap_e              last_trap_reg;

    // Decode of the offered instruction
    sdu_kind_e   dec_kind;
    logic [31:0] imm_ext;
    logic [31:0] eff_addr;
    sdu_trap_e   dec_trap;
    logic        apb_wr;
    logic        apb_rd;
    logic        ev_done;
    logic        ev_trap;

    assign dec_kind = sdu_kind_of(issue.instr);
    assign imm_ext  = {{19{issue.instr[12]}}, issue.instr[12:0]};
    assign eff_addr = (issue.instr[13] && dec_kind != SDU_KIND_ALT)
                      ? issue.src1_val + imm_ext
                      : issue.src1_val + issue.src2_val;

    // Priority: illegal, privilege, disabled unit, float error, alignment
    always_comb begin
        dec_trap = SDU_TRAP_NONE;
        if (dec_kind == SDU_KIND_NONE) begin
            dec_trap = SDU_TRAP_ILLEGAL;
        end else if (dec_kind == SDU_KIND_ALT && issue.instr[13]) begin
            dec_trap = SDU_TRAP_ILLEGAL;
        end else if ((dec_kind == SDU_KIND_ALT || dec_kind == SDU_KIND_CPQ ||
                      dec_kind == SDU_KIND_FPQ) && !ctrl_reg[`SDU_CTRL_SUPER]) begin
            dec_trap = SDU_TRAP_PRIV;
        end else if ((dec_kind == SDU_KIND_CP || dec_kind == SDU_KIND_CPQ) &&
                     !(ctrl_reg[`SDU_CTRL_COPRO_EN] && ctrl_reg[`SDU_CTRL_COPRO_PRES])) begin
            dec_trap = SDU_TRAP_COPRO_OFF;
        end else if ((dec_kind == SDU_KIND_FP || dec_kind == SDU_KIND_FPQ) &&
                     !(ctrl_reg[`SDU_CTRL_FLOAT_EN] && ctrl_reg[`SDU_CTRL_FLOAT_PRES])) begin
            dec_trap = SDU_TRAP_FLOAT_OFF;
        end else if ((dec_kind == SDU_KIND_FP || dec_kind == SDU_KIND_FPQ) &&
                     float_exc_pending) begin
            dec_trap = SDU_TRAP_FLOAT_ERR;
        end else if ((eff_addr & `SDU_DW_ALIGN_MASK) != 32'h0000_0000 ||
                     (issue.instr[25] && dec_kind != SDU_KIND_CPQ &&
                      dec_kind != SDU_KIND_FPQ)) begin
            dec_trap = SDU_TRAP_MISALIGN;
        end
    end

    assign apb_wr  = psel && penable && pwrite;
    assign apb_rd  = psel && penable && !pwrite;
    assign ev_done = (state_reg == SDU_ST_LOW) && mem_ready && !mem_fault;
    assign ev_trap = (state_reg == SDU_ST_TRAP);

    // Sequencer; nothing reaches memory until all checks pass
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= SDU_ST_IDLE;
            kind_reg  <= SDU_KIND_NONE;
            addr_reg  <= 32'h0000_0000;
            space_reg <= 8'h00;
            last_trap_reg <= SDU_TRAP_NONE;
        end else if (clk_en) begin
            case (state_reg)
                SDU_ST_IDLE: begin
                    if (issue_valid) begin
                        kind_reg  <= dec_kind;
                        addr_reg  <= eff_addr;
                        space_reg <= issue.instr[12:5];
                        last_trap_reg <= dec_trap;
                        state_reg <= (dec_trap == SDU_TRAP_NONE) ? SDU_ST_FETCH
                                                                 : SDU_ST_TRAP;
                    end
                end
                SDU_ST_FETCH: begin
                    if (pair_valid) begin
                        state_reg <= SDU_ST_HIGH;
                    end
                end
                SDU_ST_HIGH: begin
                    if (mem_ready && mem_fault) begin
                        last_trap_reg <= SDU_TRAP_DATA_FAULT;
                        state_reg <= SDU_ST_TRAP;
                    end else if (mem_ready) begin
                        state_reg <= SDU_ST_LOW;
                    end
                end
                SDU_ST_LOW: begin
                    if (mem_ready) begin
                        if (mem_fault) begin
                            last_trap_reg <= SDU_TRAP_DATA_FAULT;
                            state_reg <= SDU_ST_TRAP;
                        end else begin
                            state_reg <= SDU_ST_IDLE;
                        end
                    end
                end
                SDU_ST_TRAP: state_reg <= SDU_ST_IDLE;
                default: state_reg <= SDU_ST_IDLE;
            endcase
        end
    end

    // Memory write port; the high word commits first
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mem_wr <= '0;
            lo_reg <= 32'h0000_0000;
        end else if (clk_en) begin
            if (state_reg == SDU_ST_FETCH && pair_valid) begin
                mem_wr.valid <= 1'b1;
                mem_wr.addr  <= addr_reg;
                mem_wr.data  <= pair.hi_word;
                mem_wr.space <= space_reg;
                mem_wr.alt   <= (kind_reg == SDU_KIND_ALT);
                lo_reg       <= pair.lo_word;
            end else if (state_reg == SDU_ST_HIGH && mem_ready && !mem_fault) begin
                mem_wr.addr <= addr_reg + `SDU_WORD_STEP;
                mem_wr.data <= lo_reg;
            end else if (mem_ready || state_reg == SDU_ST_IDLE) begin
                mem_wr.valid <= 1'b0;
            end
        end
    end

    // Memory system must hold the first word until the second lands
    // so a fault on either access drops both.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            issue_ready <= 1'b0;
            pair_req    <= 1'b0;
            pair_index  <= 5'h00;
            pair_kind   <= SDU_KIND_NONE;
            trap_valid  <= 1'b0;
            trap_code   <= SDU_TRAP_NONE;
            done        <= 1'b0;
        end else if (clk_en) begin
            issue_ready <= (state_reg == SDU_ST_IDLE) && !issue_valid;
            pair_req    <= (state_reg == SDU_ST_IDLE && issue_valid &&
                            dec_trap == SDU_TRAP_NONE) ||
                           (state_reg == SDU_ST_FETCH && !pair_valid);
            if (state_reg == SDU_ST_IDLE && issue_valid) begin
                pair_index <= issue.instr[29:25];
                pair_kind  <= dec_kind;
            end
            trap_valid <= ev_trap;
            trap_code  <= last_trap_reg;
            done       <= ev_done;
        end
    end

    // Float queue bookkeeping; nonzero depth is the queue-not-empty flag
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            fq_depth_reg <= '0;
            fq_advance   <= 1'b0;
        end else if (clk_en) begin
            fq_advance <= 1'b0;
            if (apb_wr && paddr == `SDU_ADDR_FQ_DEPTH) begin
                fq_depth_reg <= pwdata[FQ_DEPTH_W-1:0];
            end else if (ev_done && kind_reg == SDU_KIND_FPQ &&
                         ctrl_reg[`SDU_CTRL_FLOAT_EXC] && fq_depth_reg != '0) begin
                fq_depth_reg <= fq_depth_reg - 1'b1;
                fq_advance   <= 1'b1;
            end
        end
    end

    // Registers and interrupt; a read of status clears it, new events win
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_reg     <= `SDU_CTRL_RESET;
            int_mask_reg <= '0;
            int_stat_reg <= '0;
            irq          <= 1'b0;
        end else if (clk_en) begin
            if (apb_wr && paddr == `SDU_ADDR_CTRL) begin
                ctrl_reg <= pwdata;
            end
            if (apb_wr && paddr == `SDU_ADDR_INT_MASK) begin
                int_mask_reg <= pwdata[`SDU_INT_WIDTH-1:0];
            end
            int_stat_reg <= ((apb_rd && paddr == `SDU_ADDR_INT_STAT) ? '0 : int_stat_reg)
                            | {ev_trap, ev_done};
            irq <= |(int_stat_reg & int_mask_reg);
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else if (clk_en) begin
            pready  <= psel && !penable;
            pslverr <= 1'b0;
            if (psel && !penable) begin
                prdata <= 32'h0000_0000;
                case (paddr)
                    `SDU_ADDR_CTRL:      prdata <= ctrl_reg;
                    `SDU_ADDR_STATUS:    prdata <= {29'h0, state_reg};
                    `SDU_ADDR_INT_STAT:  prdata <= {30'h0, int_stat_reg};
                    `SDU_ADDR_INT_MASK:  prdata <= {30'h0, int_mask_reg};
                    `SDU_ADDR_FQ_DEPTH:  prdata <= 32'(fq_depth_reg);
                    `SDU_ADDR_LAST_TRAP: prdata <= {28'h0, last_trap_reg};
                    default:             pslverr <= 1'b1;
                endcase
            end
        end
    end

    property p_trap_no_write;
        @(posedge clk) disable iff (!rst_b)
        (clk_en && state_reg == SDU_ST_IDLE && issue_valid && dec_trap != SDU_TRAP_NONE)
        |=> !mem_wr.valid;
    endproperty
    a_trap_no_write: assert property (p_trap_no_write) else $error("write after trap");

    property p_second_addr;
        @(posedge clk) disable iff (!rst_b)
        (clk_en && state_reg == SDU_ST_HIGH && mem_ready && !mem_fault)
        |=> mem_wr.addr == $past(mem_wr.addr) + 32'h0000_0004;
    endproperty
    a_second_addr: assert property (p_second_addr) else $error("low word address");

    property p_aligned;
        @(posedge clk) disable iff (!rst_b)
        (state_reg == SDU_ST_HIGH) |-> addr_reg[2:0] == 3'h0;
    endproperty
    a_aligned: assert property (p_aligned) else $error("misaligned issue");

    // Fault on either word is reported one cycle after the trap state
    sequence s_fault_report;
        state_reg == SDU_ST_TRAP ##1 (trap_code == SDU_TRAP_DATA_FAULT);
    endsequence

    property p_fault_trap;
        @(posedge clk) disable iff (!rst_b)
        (clk_en && (state_reg == SDU_ST_HIGH || state_reg == SDU_ST_LOW)
         && mem_ready && mem_fault)
        |=> s_fault_report;
    endproperty
    a_fault_trap: assert property (p_fault_trap) else $error("fault not trapped");

    property p_alt_imm;
        @(posedge clk) disable iff (!rst_b)
        (state_reg == SDU_ST_IDLE && issue_valid && dec_kind == SDU_KIND_ALT
         && issue.instr[13]) |-> dec_trap == SDU_TRAP_ILLEGAL;
    endproperty
    a_alt_imm: assert property (p_alt_imm) else $error("alt immediate");

    property p_copro_off;
        @(posedge clk) disable iff (!rst_b)
        (issue_valid && dec_kind == SDU_KIND_CP && !ctrl_reg[`SDU_CTRL_COPRO_EN])
        |-> dec_trap == SDU_TRAP_COPRO_OFF;
    endproperty
    a_copro_off: assert property (p_copro_off) else $error("copro enable");

    property p_float_off;
        @(posedge clk) disable iff (!rst_b)
        (issue_valid && dec_kind == SDU_KIND_FP && !ctrl_reg[`SDU_CTRL_FLOAT_PRES])
        |-> dec_trap == SDU_TRAP_FLOAT_OFF;
    endproperty
    a_float_off: assert property (p_float_off) else $error("float present");

    property p_fq_advance;
        @(posedge clk) disable iff (!rst_b)
        fq_advance |-> fq_depth_reg == $past(fq_depth_reg) - 1'b1;
    endproperty
    a_fq_advance: assert property (p_fq_advance) else $error("queue advance");

endmodule
`default_nettype wire

//--- test/sdu_mem_model.sv
`timescale 1ns/100ps
`default_nettype none

module sdu_mem_model
    import sdu_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        pair_req,
    input  wire logic [4:0]  pair_index,
    input  wire sdu_kind_e   pair_kind,
    output var  logic        pair_valid,
    output var  sdu_pair_s   pair,
    input  wire sdu_mem_s    mem_wr,
    output var  logic        mem_ready,
    output var  logic        mem_fault,
    input  wire logic        fault_on,
    output var  logic        cm_valid,
    output var  logic [31:0] cm_addr,
    output var  logic [31:0] cm_hi,
    output var  logic [31:0] cm_lo,
    output var  logic [7:0]  cm_space,
    output var  logic        cm_adj
);
    logic [1:0]  wait_cnt;
    logic        slow;
    logic        sent;
    logic        first;
    logic [31:0] a0;
    logic [31:0] d0;
    logic [7:0]  s0;
    wire  [31:0] hi_w = {16'h5A00, 5'h00, pair_kind, 3'h0, pair_index};

    // Alternates prompt and slow answers
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            {wait_cnt, slow, sent, first, pair_valid, mem_ready, mem_fault} <= '0;
            {cm_valid, cm_addr, cm_hi, cm_lo, cm_space, cm_adj, a0, d0, s0} <= '0;
            pair <= '0;
        end else begin
            pair_valid <= 1'b0;
            cm_valid <= 1'b0;
            pair <= ~pair;
            if (!pair_req) begin
                sent <= 1'b0;
            end else if (!sent) begin
                if (wait_cnt == {slow, 1'b0}) begin
                    pair_valid <= 1'b1;
                    pair <= {hi_w, ~hi_w};
                    sent <= 1'b1;
                    wait_cnt <= 2'h0;
                end else begin
                    wait_cnt <= wait_cnt + 2'h1;
                end
            end
            if (mem_ready) begin
                mem_ready <= 1'b0;
                mem_fault <= 1'b0;
                slow <= ~slow;
                first <= ~first;
                if (!first) begin
                    a0 <= mem_wr.addr;
                    d0 <= mem_wr.data;
                    s0 <= mem_wr.space;
                end else if (!mem_fault) begin
                    cm_valid <= 1'b1;
                    cm_addr <= a0;
                    cm_hi <= d0;
                    cm_lo <= mem_wr.data;
                    cm_space <= s0;
                    cm_adj <= (mem_wr.addr == a0 + 32'h4) && (mem_wr.space == s0);
                end
            end else if (mem_wr.valid) begin
                if (wait_cnt == {slow, 1'b0}) begin
                    mem_ready <= 1'b1;
                    mem_fault <= fault_on & first;
                    wait_cnt <= 2'h0;
                end else begin
                    wait_cnt <= wait_cnt + 2'h1;
                end
            end
        end
    end
endmodule

`default_nettype wire

//--- test/tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "sdu_params.svh"

module tb import sdu_pkg::*; ;
    typedef struct {
        logic        is_trap;
        sdu_trap_e   code;
        logic [31:0] addr;
        logic [31:0] hi;
        logic        alt;
        logic [7:0]  sp;
    } sdu_exp_s;

    logic        clk, rst_b, issue_valid, issue_ready, pair_req, pair_valid, mem_ready;
    logic        mem_fault, fexc, fault_on, fq_advance, trap_valid, done, irq;
    logic        psel, penable, pwrite, pready, pslverr, cm_valid, cm_adj, err, clk_en;
    logic [4:0]  pair_index;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, cm_addr, cm_hi, cm_lo, seed, r;
    logic [7:0]  cm_space;
    sdu_kind_e   pair_kind;
    sdu_trap_e   trap_code;
    sdu_issue_s  issue;
    sdu_pair_s   pair;
    sdu_mem_s    mem_wr;
    sdu_exp_s    q[$];
    sdu_exp_s    e;
    int          fail_count, n_checks, fq_seen, n;
    logic [5:0]  ops [7];

    sdu_store_double dut (.clk, .rst_b, .clk_en, .issue_valid, .issue, .issue_ready,
        .pair_index, .pair_kind, .pair_req, .pair_valid, .pair, .float_exc_pending(fexc),
        .mem_wr, .mem_ready, .mem_fault, .fq_advance, .trap_valid, .trap_code, .done, .irq,
        .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
    sdu_mem_model mem (.clk, .rst_b, .pair_req, .pair_index, .pair_kind, .pair_valid, .pair,
        .mem_wr, .mem_ready, .mem_fault, .fault_on, .cm_valid, .cm_addr, .cm_hi, .cm_lo,
        .cm_space, .cm_adj);

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task end_of_test;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        r = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    function automatic sdu_trap_e exp_trap(input logic [5:0] op, c, input logic i, odd, fx,
                                           input logic [31:0] ea);
        logic qs, cp, fp, pv;
        qs = op == `SDU_OP_STORE_COPRO_QUEUE_ENTRY || op == `SDU_OP_STORE_FLOAT_QUEUE_ENTRY;
        cp = op == `SDU_OP_STORE_DOUBLE_COPRO || op == `SDU_OP_STORE_COPRO_QUEUE_ENTRY;
        fp = op == `SDU_OP_STORE_DOUBLE_FLOAT || op == `SDU_OP_STORE_FLOAT_QUEUE_ENTRY;
        pv = qs || op == `SDU_OP_STDA;
        if (!(cp || fp || pv || op == `SDU_OP_STD) || (op == `SDU_OP_STDA && i))
            return SDU_TRAP_ILLEGAL;
        if (pv && !c[2]) return SDU_TRAP_PRIV;
        if (cp && !(c[0] && c[3])) return SDU_TRAP_COPRO_OFF;
        if (fp && !(c[1] && c[4])) return SDU_TRAP_FLOAT_OFF;
        if (fp && fx) return SDU_TRAP_FLOAT_ERR;
        if (ea[2:0] != 3'h0 || (odd && !qs)) return SDU_TRAP_MISALIGN;
        return SDU_TRAP_NONE;
    endfunction

    task run(input logic [5:0] op, c, input logic i, odd, mis, fx, flt);
        logic [31:0] s1, s2, ea;
        logic [4:0]  rd;
        logic [2:0]  k;
        sdu_exp_s    x;
        int          w;
        apb(1'b1, `SDU_ADDR_CTRL, {26'h0, c});
        s1 = rnd();
        s1[2:0] = {mis, 2'b00};
        s2 = rnd() & 32'hFFFF_FFF8;
        rd = {s2[20:17], odd};
        case (op)
            `SDU_OP_STD:   k = SDU_KIND_INT;
            `SDU_OP_STDA:  k = SDU_KIND_ALT;
            `SDU_OP_STORE_DOUBLE_COPRO:  k = SDU_KIND_CP;
            `SDU_OP_STORE_COPRO_QUEUE_ENTRY: k = SDU_KIND_CPQ;
            `SDU_OP_STORE_DOUBLE_FLOAT:  k = SDU_KIND_FP;
            default:       k = SDU_KIND_FPQ;
        endcase
        ea = s1 + ((i && op != `SDU_OP_STDA) ? {{19{s2[12]}}, s2[12:3], 3'h0} : s2);
        x.code = exp_trap(op, c, i, odd, fx, ea);
        if (x.code == SDU_TRAP_NONE && flt) x.code = SDU_TRAP_DATA_FAULT;
        x.is_trap = x.code != SDU_TRAP_NONE;
        x.addr = ea;
        x.hi = {16'h5A00, 5'h00, k, 3'h0, rd};
        x.alt = op == `SDU_OP_STDA;
        x.sp = s1[15:8];
        q.push_back(x);
        fault_on <= flt;
        fexc <= fx;
        issue <= {2'b11, rd, op, 5'h00, i, i ? {s2[12:3], 3'h0} : {s1[15:8], 5'h00}, s1, s2};
        issue_valid <= 1'b1;
        @(posedge clk);
        issue_valid <= 1'b0;
        w = 0;
        while (done !== 1'b1 && trap_valid !== 1'b1 && w < 300) begin
            @(posedge clk);
            w++;
        end
        chk({31'h0, w < 300}, 32'h1);
        repeat (3) @(posedge clk);
    endtask

    // Scoreboard: each commit or trap consumes the oldest note
    always @(posedge clk) begin
        if (fq_advance === 1'b1) fq_seen++;
        if (cm_valid === 1'b1 || trap_valid === 1'b1) begin
            if (q.size() == 0) begin
                chk(32'h0, 32'h1);
            end else begin
                e = q.pop_front();
                chk({31'h0, trap_valid}, {31'h0, e.is_trap});
                if (e.is_trap) begin
                    chk({28'h0, trap_code}, {28'h0, e.code});
                end else begin
                    chk(cm_addr, e.addr);
                    chk(cm_hi, e.hi);
                    chk(cm_lo, ~e.hi);
                    chk({31'h0, cm_adj}, 32'h1);
                    chk({31'h0, mem_wr.alt}, {31'h0, e.alt});
                    if (e.alt) chk({24'h0, cm_space}, {24'h0, e.sp});
                end
            end
        end
    end

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    initial begin
        #(40 * 60000);
        fail_count++;
        end_of_test;
    end

    initial begin
        {rst_b, issue_valid, fexc, fault_on, psel, penable, pwrite} = '0;
        {issue, paddr, pwdata} = '0;
        clk_en = 1'b1;
        {fail_count, n_checks, fq_seen} = '0;
        seed = 32'd75550;
        ops = '{`SDU_OP_STD, `SDU_OP_STDA, `SDU_OP_STORE_DOUBLE_COPRO, `SDU_OP_STORE_COPRO_QUEUE_ENTRY, `SDU_OP_STORE_DOUBLE_FLOAT,
                `SDU_OP_STORE_FLOAT_QUEUE_ENTRY, 6'h04};
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        apb(1'b0, `SDU_ADDR_CTRL, 32'h0);
        chk(r, `SDU_CTRL_RESET);
        apb(1'b0, `SDU_ADDR_INT_MASK, 32'h0);
        chk(r, 32'h0);
        apb(1'b0, `SDU_ADDR_FQ_DEPTH, 32'h0);
        chk(r, 32'h0);
        apb(1'b0, `SDU_ADDR_STATUS, 32'h0);
        chk(r, 32'h0);
        apb(1'b0, 12'h100, 32'h0);
        chk({31'h0, err}, 32'h1);
        // Frozen: an offered illegal word must neither be taken nor trap
        clk_en <= 1'b0;
        issue_valid <= 1'b1;
        repeat (4) @(posedge clk);
        chk({30'h0, issue_ready, pair_req}, 32'h2);
        clk_en <= 1'b1;
        issue_valid <= 1'b0;
        // Clean passes, then faults, then random modes
        for (n = 0; n < 84; n++) begin
            if (n < 14) begin
                run(ops[n % 7], 6'h1F, n >= 7, 1'b0, 1'b0, 1'b0, 1'b0);
            end else if (n < 21) begin
                run(ops[n % 7], 6'h1F, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
            end else begin
                r = rnd();
                run(ops[n % 7], r[5:0], r[6], r[7], r[8] & r[9], r[10], 1'b0);
            end
        end
        apb(1'b0, `SDU_ADDR_INT_STAT, 32'h0);
        chk(r, 32'h3);
        apb(1'b1, `SDU_ADDR_INT_MASK, 32'h2);
        run(`SDU_OP_STD, 6'h1F, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
        chk({31'h0, irq}, 32'h0);
        run(`SDU_OP_STD, 6'h1F, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
        chk({31'h0, irq}, 32'h1);
        apb(1'b0, `SDU_ADDR_LAST_TRAP, 32'h0);
        chk(r, 32'h3);
        apb(1'b0, `SDU_ADDR_INT_STAT, 32'h0);
        chk(r, 32'h3);
        repeat (3) @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, `SDU_ADDR_FQ_DEPTH, 32'h1);
        run(`SDU_OP_STORE_FLOAT_QUEUE_ENTRY, 6'h3F, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
        run(`SDU_OP_STORE_FLOAT_QUEUE_ENTRY, 6'h3F, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
        apb(1'b0, `SDU_ADDR_FQ_DEPTH, 32'h0);
        chk(r, 32'h0);
        chk(fq_seen, 32'h1);
        end_of_test;
    end
endmodule

`default_nettype wire
